// File: dv/src_model.sv
`timescale 1ns/1ps
`include "irq_status_cfg.svh"

// far side: timer, serial unit, modulator two and the five request pins
module src_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [31:0] i_want, // wished requests, laid out as status bits
	output logic o_tick,
	output logic o_serial,
	output logic o_mod,
	output irq_status_pkg::ext_pins_t o_pins_n
);
	// peripheral flags are same-clock levels, held while the event lasts
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_tick <= 1'b0;
			o_serial <= 1'b0;
			o_mod <= 1'b0;
		end else begin
			o_tick <= i_want[`BIT_TICK];
			o_serial <= i_want[`BIT_SERIAL_ONE];
			o_mod <= i_want[`BIT_MOD_TWO];
		end
	end

	// pins idle high; a requester holds its line low until it withdraws
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pins_n <= 5'h1f;
		end else begin
			o_pins_n.five_n <= ~i_want[`BIT_EXT_FIVE];
			o_pins_n.six_n <= ~i_want[`BIT_EXT_SIX];
			o_pins_n.three_n <= ~i_want[`BIT_EXT_THREE];
			o_pins_n.two_n <= ~i_want[`BIT_EXT_TWO];
			o_pins_n.one_n <= ~i_want[`BIT_EXT_ONE];
		end
	end
endmodule : src_model

// File: dv/tb.sv
`timescale 1ns/1ps
`include "irq_status_cfg.svh"

// random sources and masks against an integer model of the status word
module tb;
	logic i_clk, i_rst_n, i_wr, i_rd, o_irq, tick, serial, mod;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata, o_request_status, want;
	logic [2:0] o_modulator_two_level, lvl;
	irq_status_pkg::ext_pins_t pins_n;
	logic [31:0] mask, edge_sel, lat, st, ev, nmask, prev, v, raw; // model state
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;

	src_model far (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_want(want), .o_tick(tick), .o_serial(serial),
		.o_mod(mod), .o_pins_n(pins_n));
	irq_status_upper dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_periodic_tick_flag(tick), .i_serial_unit_one_flag(serial),
		.i_modulator_two_flag(mod), .i_ext_request_level_one_n(pins_n.one_n),
		.i_ext_request_level_two_n(pins_n.two_n), .i_ext_request_level_three_n(pins_n.three_n),
		.i_ext_request_level_five_n(pins_n.five_n), .i_ext_request_level_six_n(pins_n.six_n),
		.o_request_status(o_request_status), .o_modulator_two_level(o_modulator_two_level), .o_irq(o_irq));

	// 10 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// hang guard, far above the roughly 2400 cycles of the run
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// one-cycle write strobe; next call starts on a fresh edge
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(name, o_rdata, exp);
	endtask : rd

	// let pins pass the synchroniser, then advance the model
	task settle;
		repeat (8) @(posedge i_clk);
		#1;
		prev = st;
		raw = ((want & ~edge_sel) | (lat & edge_sel)) & `STATUS_USED;
		st = raw & ~mask;
		ev = ev | (st & ~prev);
	endtask : settle

	task set_req(input logic [31:0] n);
		lat = lat | (n & ~want & edge_sel);
		want <= n;
		settle();
	endtask : set_req

	initial begin
		i_rst_n = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		want = 32'h0;
		{edge_sel, lat, st, ev, nmask} = '0;
		mask = `RST_REQ_MASK;
		lvl = `RST_MOD_TWO_LEVEL;
		v = $urandom(1243);
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(`OFS_REQ_MASK, `RST_REQ_MASK, "mask");
		rd(`OFS_EDGE_SELECT, `RST_EDGE_SELECT, "edge select");
		rd(`OFS_NOTIFY_MASK, `RST_NOTIFY_MASK, "event mask");
		rd(`OFS_REQ_STATUS, 32'h0, "status");
		rd(8'h20, 32'h0, "unmapped");
		$display("reset values done");
		// every level code, 0 and 7 refused
		for (int i = 0; i < 8; i++) begin
			wr(`OFS_MOD_TWO_LEVEL, i);
			if (i >= 1 && i <= 6) begin
				lvl = 3'(i);
			end
			// the level flop updates on the write edge; look once it has settled
			#1;
			chk("mod level", {29'h0, o_modulator_two_level}, {29'h0, lvl});
		end
		rd(`OFS_MOD_TWO_LEVEL, {29'h0, lvl}, "mod level read");
		$display("modulator level done");
		// level phase, then edge phase for lines one, two, three, six
		for (int ph = 0; ph < 2; ph++) begin
			set_req(32'h0);
			edge_sel = ph ? `EDGE_USED : 32'h0;
			wr(`OFS_EDGE_SELECT, edge_sel);
			rd(`OFS_NOTIFY_STATUS, ev, "event flush");
			ev = 32'h0;
			for (int k = 0; k < 30; k++) begin
				v = $urandom;
				mask = v & `STATUS_USED;
				wr(`OFS_REQ_MASK, v);
				settle();
				nmask = $urandom & `STATUS_USED;
				wr(`OFS_NOTIFY_MASK, nmask);
				set_req($urandom & `STATUS_USED);
				chk("status", o_request_status, st);
				chk("irq", {31'h0, o_irq}, {31'h0, |(ev & nmask)});
				rd(`OFS_REQ_STATUS, st, "status read");
				rd(`OFS_REQ_RAW, raw, "raw sources");
				// reserved bits are always written as zero
				v = $urandom & `STATUS_USED;
				wr(`OFS_REQ_STATUS, v);
				lat = lat & ~(v & edge_sel);
				settle();
				chk("status after clear", o_request_status, st);
				rd(`OFS_NOTIFY_STATUS, ev, "event word");
				ev = 32'h0;
				repeat (2) @(posedge i_clk);
				#1;
				chk("irq cleared", {31'h0, o_irq}, 32'h0);
			end
			$display("phase %0d done", ph);
		end
		// fresh edge on line one lands in the very cycle of its write-one clear
		set_req(32'h0);
		mask = 32'h0;
		wr(`OFS_REQ_MASK, mask);
		want <= 32'h00010000;
		lat[`BIT_EXT_ONE] = 1'b1;
		// pin moves next edge, two sync stages, edge seen with the write strobe
		repeat (2) @(posedge i_clk);
		wr(`OFS_REQ_STATUS, 32'h00010000);
		settle();
		chk("edge beats clear", o_request_status, st);
		$display("edge against clear done");
		wr(8'h20, $urandom);
		rd(`OFS_REQ_MASK, mask, "mask after unmapped write");
		end_of_test();
	end
endmodule : tb

// File: hdl/ext_request_cell.sv
`timescale 1ns/1ps

// one external request line: synchroniser, edge latch or level follower
module ext_request_cell #(
	parameter bit EDGE_CAPABLE = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_pin_n,
	input wire logic i_edge_mode,
	input wire logic i_clear,
	output logic o_pending
);
	logic sync1_reg; // first stage, read only by the second
	logic sync2_reg; // safe copy of the pin
	logic prev_active_reg; // last sampled request level
	logic pending_reg; // latched or followed request
	logic active; // request asserted (pin low)
	logic fall; // new active edge this cycle
	logic edge_mode; // edge mode only where the line supports it

	assign active = ~sync2_reg;
	assign fall = active & ~prev_active_reg;
	assign edge_mode = EDGE_CAPABLE & i_edge_mode;
	assign o_pending = pending_reg;

	// two-stage synchroniser; idle pin is high
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= i_pin_n;
			sync2_reg <= sync1_reg;
		end
	end

	// previous level for edge detection
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_active_reg <= 1'b0;
		end else begin
			prev_active_reg <= active;
		end
	end

	// edge mode latches until a write of one; a fresh edge beats the clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pending_reg <= 1'b0;
		end else if (edge_mode) begin
			pending_reg <= fall | (pending_reg & ~i_clear);
		end else begin
			pending_reg <= active;
		end
	end

	sequence s_fresh_edge;
		edge_mode && fall;
	endsequence

	sequence s_plain_clear;
		edge_mode && i_clear && !fall;
	endsequence

	a_edge_beats_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_fresh_edge |=> pending_reg)
		else $error("edge lost against clear");

	a_write_one_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_plain_clear |=> !pending_reg)
		else $error("write of one did not clear");

	a_level_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!edge_mode && !i_pin_n) |=> ##2 (!edge_mode && !$past(i_pin_n, 3)) |-> pending_reg)
		else $error("level request not followed");

	a_edge_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(edge_mode && pending_reg && !i_clear) |=> pending_reg)
		else $error("latched edge dropped without clear");
endmodule : ext_request_cell

// File: hdl/irq_status_cfg.svh
`ifndef IRQ_STATUS_CFG_SVH
`define IRQ_STATUS_CFG_SVH

// register offsets on the plain register port (byte addresses)
`define OFS_REQ_MASK 8'h00
`define OFS_EDGE_SELECT 8'h04
`define OFS_MOD_TWO_LEVEL 8'h08
`define OFS_REQ_STATUS 8'h0c
`define OFS_REQ_RAW 8'h10
`define OFS_NOTIFY_STATUS 8'h14
`define OFS_NOTIFY_MASK 8'h18

// field positions inside the request status word
`define BIT_TICK 22
`define BIT_SERIAL_ONE 21
`define BIT_EXT_FIVE 20
`define BIT_EXT_SIX 19
`define BIT_EXT_THREE 18
`define BIT_EXT_TWO 17
`define BIT_EXT_ONE 16
`define BIT_MOD_TWO 13
`define BIT_EXT_BASE 16

// bits that exist, and the external bits that may run edge-triggered
`define STATUS_USED 32'h007f2000
`define EDGE_USED 32'h000f0000

// reset values
`define RST_REQ_MASK 32'h007f2000
`define RST_EDGE_SELECT 32'h00000000
`define RST_NOTIFY_MASK 32'h00000000
`define RST_MOD_TWO_LEVEL 3'h6

// legal range of the modulator two priority level
`define MOD_LEVEL_MIN 3'h1
`define MOD_LEVEL_MAX 3'h6

`endif

// File: hdl/irq_status_pkg.sv
package irq_status_pkg;
	// one access on the register port
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// full register word
	typedef logic [31:0] word_t;

	// the five external request pins, active low
	typedef struct packed {
		logic five_n;
		logic six_n;
		logic three_n;
		logic two_n;
		logic one_n;
	} ext_pins_t;
endpackage : irq_status_pkg

// File: hdl/irq_status_upper.sv
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "irq_status_cfg.svh"

module irq_status_upper (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_periodic_tick_flag,
	input wire logic i_serial_unit_one_flag,
	input wire logic i_modulator_two_flag,
	input wire logic i_ext_request_level_one_n,
	input wire logic i_ext_request_level_two_n,
	input wire logic i_ext_request_level_three_n,
	input wire logic i_ext_request_level_five_n,
	input wire logic i_ext_request_level_six_n,
	output logic [31:0] o_request_status,
	output logic [2:0] o_modulator_two_level,
	output logic o_irq
);
	// address match on the register port
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	// legal modulator level check
	function automatic logic level_ok(input logic [2:0] lvl);
		level_ok = (lvl >= `MOD_LEVEL_MIN) && (lvl <= `MOD_LEVEL_MAX);
	endfunction : level_ok

	irq_status_pkg::reg_req_t req; // bundled port access
	irq_status_pkg::ext_pins_t pins; // bundled request pins
	irq_status_pkg::word_t mask_reg; // 1 blocks a source from the core
	irq_status_pkg::word_t edge_sel_reg; // 1 selects edge trigger
	irq_status_pkg::word_t status_reg; // requests posted to the core
	irq_status_pkg::word_t notify_reg; // sticky newly-posted events
	irq_status_pkg::word_t notify_mask_reg; // 1 lets an event drive o_irq
	irq_status_pkg::word_t rdata_reg; // read answer, one cycle late
	irq_status_pkg::word_t raw_req; // every source before masking
	irq_status_pkg::word_t status_next; // posted view for next cycle
	irq_status_pkg::word_t notify_next; // sticky events for next cycle
	irq_status_pkg::word_t notify_clr; // read clear of the event word
	logic [2:0] mod_level_reg; // priority level of modulator two
	logic irq_reg; // interrupt output flop
	logic [4:0] ext_pin_n; // pins in bit order 16..20
	logic [4:0] ext_pend; // per-line latched or followed request
	logic [4:0] ext_clear; // write-one clear per line
	logic wr_status; // write aimed at the status word

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	assign pins = '{five_n: i_ext_request_level_five_n, six_n: i_ext_request_level_six_n,
		three_n: i_ext_request_level_three_n, two_n: i_ext_request_level_two_n,
		one_n: i_ext_request_level_one_n};
	// order matches status bits 16 (one) up to 20 (five)
	assign ext_pin_n = {pins.five_n, pins.six_n, pins.three_n, pins.two_n, pins.one_n};
	assign wr_status = req.wr && hit(req.addr, `OFS_REQ_STATUS);

	assign o_rdata = rdata_reg;
	assign o_request_status = status_reg;
	assign o_modulator_two_level = mod_level_reg;
	assign o_irq = irq_reg;

	// one cell per external line; level five has no edge mode, so no clear
	for (genvar k = 0; k < 5; k++) begin : g_ext
		// only a one written to a line in edge mode clears it; zeros do nothing
		assign ext_clear[k] = wr_status && req.wdata[`BIT_EXT_BASE + k]
			&& edge_sel_reg[`BIT_EXT_BASE + k];
		ext_request_cell #(
			.EDGE_CAPABLE(k != 4)
		) u_cell (
			.i_clk(i_clk),
			.i_rst_n(i_rst_n),
			.i_pin_n(ext_pin_n[k]),
			.i_edge_mode(edge_sel_reg[`BIT_EXT_BASE + k]),
			.i_clear(ext_clear[k]),
			.o_pending(ext_pend[k])
		);
	end

	// gather the sources into the status layout
	always_comb begin
		raw_req = '0;
		raw_req[`BIT_TICK] = i_periodic_tick_flag;
		raw_req[`BIT_SERIAL_ONE] = i_serial_unit_one_flag;
		raw_req[`BIT_EXT_FIVE] = ext_pend[4];
		raw_req[`BIT_EXT_SIX] = ext_pend[3];
		raw_req[`BIT_EXT_THREE] = ext_pend[2];
		raw_req[`BIT_EXT_TWO] = ext_pend[1];
		raw_req[`BIT_EXT_ONE] = ext_pend[0];
		raw_req[`BIT_MOD_TWO] = i_modulator_two_flag;
	end

	// masked sources stay out; reserved bits 15-14 never carry state
	assign status_next = raw_req & ~mask_reg & `STATUS_USED;

	// posted status, refreshed every cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	// mask register: only implemented bits are stored
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask_reg <= `RST_REQ_MASK;
		end else if (req.wr && hit(req.addr, `OFS_REQ_MASK)) begin
			mask_reg <= req.wdata & `STATUS_USED;
		end
	end

	// trigger select for lines one, two, three and six
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			edge_sel_reg <= `RST_EDGE_SELECT;
		end else if (req.wr && hit(req.addr, `OFS_EDGE_SELECT)) begin
			edge_sel_reg <= req.wdata & `EDGE_USED;
		end
	end

	// modulator two level; an illegal code is refused, not stored
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mod_level_reg <= `RST_MOD_TWO_LEVEL;
		end else if (req.wr && hit(req.addr, `OFS_MOD_TWO_LEVEL) && level_ok(req.wdata[2:0])) begin
			mod_level_reg <= req.wdata[2:0];
		end
	end

	// event word: a newly posted bit is sticky until read; set beats read clear
	always_comb begin
		notify_clr = '0;
		if (req.rd && hit(req.addr, `OFS_NOTIFY_STATUS)) begin
			notify_clr = '1;
		end
		notify_next = (notify_reg & ~notify_clr) | (status_next & ~status_reg);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			notify_reg <= '0;
		end else begin
			notify_reg <= notify_next;
		end
	end

	// event mask
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			notify_mask_reg <= `RST_NOTIFY_MASK;
		end else if (req.wr && hit(req.addr, `OFS_NOTIFY_MASK)) begin
			notify_mask_reg <= req.wdata & `STATUS_USED;
		end
	end

	// level interrupt, registered so the output is glitch free
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(notify_next & notify_mask_reg);
		end
	end

	// read answer; unmapped addresses and idle cycles return zero
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_reg <= '0;
		end else if (!req.rd) begin
			rdata_reg <= '0;
		end else begin
			unique case (req.addr)
				`OFS_REQ_MASK: rdata_reg <= mask_reg;
				`OFS_EDGE_SELECT: rdata_reg <= edge_sel_reg;
				`OFS_MOD_TWO_LEVEL: rdata_reg <= {29'h0, mod_level_reg};
				`OFS_REQ_STATUS: rdata_reg <= status_reg;
				`OFS_REQ_RAW: rdata_reg <= raw_req & `STATUS_USED;
				`OFS_NOTIFY_STATUS: rdata_reg <= notify_reg;
				`OFS_NOTIFY_MASK: rdata_reg <= notify_mask_reg;
				default: rdata_reg <= '0;
			endcase
		end
	end

	sequence s_status_read;
		req.rd && hit(req.addr, `OFS_REQ_STATUS);
	endsequence

	sequence s_zero_write_l1;
		wr_status && !req.wdata[`BIT_EXT_ONE] && edge_sel_reg[`BIT_EXT_ONE] && ext_pend[0];
	endsequence

	a_tick_posted: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_periodic_tick_flag && !mask_reg[`BIT_TICK]) |=> status_reg[`BIT_TICK])
		else $error("tick not posted");

	a_serial_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_serial_unit_one_flag |=> !status_reg[`BIT_SERIAL_ONE])
		else $error("serial bit set without event");

	a_masked_hidden: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		1'b1 |=> ((status_reg & $past(mask_reg)) == '0))
		else $error("masked request visible");

	a_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_status_read |=> (o_rdata[15:14] == 2'b00) && (o_rdata == $past(status_reg)))
		else $error("status read wrong");

	a_zero_write_keeps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_zero_write_l1 |=> ext_pend[0])
		else $error("write of zero cleared a bit");

	a_mod_level_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		level_ok(mod_level_reg))
		else $error("modulator level out of range");

	a_level_five_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_ext_request_level_five_n && !mask_reg[`BIT_EXT_FIVE]) [*4] |=> status_reg[`BIT_EXT_FIVE])
		else $error("level five request not posted");

	a_level_six_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_ext_request_level_six_n && !edge_sel_reg[`BIT_EXT_SIX] && !mask_reg[`BIT_EXT_SIX]) [*4]
		|=> status_reg[`BIT_EXT_SIX])
		else $error("level six request not posted");

	// interrupt level only judged while the event mask holds still; a mask write lags one cycle
	a_irq_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$stable(notify_mask_reg) |-> (o_irq == |(notify_reg & notify_mask_reg)))
		else $error("interrupt output wrong");

	// a read of the event word, the only access that clears event bits
	sequence s_event_read;
		req.rd && hit(req.addr, `OFS_NOTIFY_STATUS);
	endsequence

	// a refused level code reaching the level register
	sequence s_bad_level_write;
		req.wr && hit(req.addr, `OFS_MOD_TWO_LEVEL) && !level_ok(req.wdata[2:0]);
	endsequence

	// internal sources: one cycle from flag to posted bit, both ways
	a_tick_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_periodic_tick_flag |=> !status_reg[`BIT_TICK])
		else $error("tick bit set without timer flag");

	a_serial_posted: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_serial_unit_one_flag && !mask_reg[`BIT_SERIAL_ONE]) |=> status_reg[`BIT_SERIAL_ONE])
		else $error("serial event not posted");

	a_mod_two_posted: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_modulator_two_flag && !mask_reg[`BIT_MOD_TWO]) |=> status_reg[`BIT_MOD_TWO])
		else $error("modulator two event not posted");

	a_mod_two_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_modulator_two_flag |=> !status_reg[`BIT_MOD_TWO])
		else $error("modulator two bit set without event");

	// level-mode pins: two sync stages, the cell, then the status flop
	a_level_three_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_ext_request_level_three_n && !edge_sel_reg[`BIT_EXT_THREE] && !mask_reg[`BIT_EXT_THREE]) [*4]
		|=> status_reg[`BIT_EXT_THREE])
		else $error("level three request not posted");

	a_level_two_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_ext_request_level_two_n && !edge_sel_reg[`BIT_EXT_TWO] && !mask_reg[`BIT_EXT_TWO]) [*4]
		|=> status_reg[`BIT_EXT_TWO])
		else $error("level two request not posted");

	a_level_one_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!i_ext_request_level_one_n && !edge_sel_reg[`BIT_EXT_ONE] && !mask_reg[`BIT_EXT_ONE]) [*4]
		|=> status_reg[`BIT_EXT_ONE])
		else $error("level one request not posted");

	// nothing but the implemented bits ever reaches the status word
	a_status_unused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(status_reg & ~`STATUS_USED) == 32'h0)
		else $error("unimplemented status bit set");

	a_level_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_bad_level_write |=> $stable(mod_level_reg))
		else $error("illegal modulator level stored");

	// after a read only bits posted in that very cycle may remain
	a_event_read_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_event_read |=> ((notify_reg & ~status_reg) == 32'h0))
		else $error("event bit survived its read");

	// read data stands one cycle only, zero otherwise
	a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!req.rd |=> (o_rdata == 32'h0))
		else $error("read data outside its cycle");
endmodule : irq_status_upper
